// File: src/exposure_regs_consts.vh
// Constants for the exposure, gain and black level register group
// Assumes an 8-bit register address space on the serial control port
`ifndef EXPOSURE_REGS_CONSTS_VH
`define EXPOSURE_REGS_CONSTS_VH

// ***********************************************
// Register offsets
// ***********************************************
`define ADDR_ROW_DELAY_UPPER        8'h22
`define ADDR_ROW_DELAY_LOWER        8'h23
`define ADDR_INTEG_ROWS_UPPER       8'h24
`define ADDR_INTEG_ROWS_LOWER       8'h25
`define ADDR_BLACK_LOOP_CONFIG      8'h40
`define ADDR_BLACK_LOOP_TARGET      8'h41
`define ADDR_ANALOG_GAIN            8'h42
`define ADDR_BLACK_LEVEL_MANUAL     8'h46
`define ADDR_GAIN_CHANNEL_MAP       8'h4a

// ***********************************************
// Reset values
// ***********************************************
`define RST_ROW_DELAY_UPPER         8'h00
`define RST_ROW_DELAY_LOWER         8'h08
`define RST_INTEG_ROWS_UPPER        8'h00
`define RST_INTEG_ROWS_LOWER        8'h00
`define RST_BLACK_LOOP_CONFIG       8'h07
`define RST_BLACK_LOOP_TARGET       8'h10
`define RST_ANALOG_GAIN             8'h00
`define RST_BLACK_LEVEL_MANUAL      8'h00
`define RST_GAIN_CHANNEL_MAP        8'h1b

// ***********************************************
// Field positions and masks
// ***********************************************
`define BLACK_LOOP_DISABLE_BIT      3
`define BLACK_LOOP_SPEED_MSB        2
`define INTEG_UPPER_MASK            8'h0f
`define INTEG_LOWER_MASK            8'h7f
`define BLACK_CONFIG_MASK           8'h0f
`define ANALOG_GAIN_MASK            8'h7f

`endif

// File: src/double_buffer_stage.v
// Staged and active copy of one double-buffered register
// Assumes the load pulse marks a frame boundary
module double_buffer_stage
(
    // Clock and reset
    input  wire       core_clk_in,
    input  wire       rstn_in,
    // Staging
    input  wire [7:0] reset_value_in,
    input  wire       write_in,
    input  wire [7:0] write_data_in,
    input  wire       frame_load_in,
    // Values
    output reg  [7:0] staged_out,
    output reg  [7:0] active_out
);

    // ***********************************************
    // Stage and active copies
    // ***********************************************
    always @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            staged_out <= reset_value_in;
            active_out <= reset_value_in;
        end
        else
        begin
            if (write_in)
                staged_out <= write_data_in;
            if (frame_load_in)
                active_out <= write_in ? write_data_in : staged_out;
        end
    end

endmodule

// File: src/exposure_gain_blacklevel_regs.v
// Exposure, analog gain and black level register group
// Assumes a serial port decoder giving address, write and read strobes
`include "exposure_regs_consts.vh"

module exposure_gain_blacklevel_regs
(
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        rstn_in,
    // Register port
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_write_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_read_in,
    output reg  [7:0]  reg_rdata_out,
    // Frame timing
    input  wire        frame_start_in,
    input  wire [10:0] readout_row_in,
    // Exposure outputs
    output reg  [12:0] row_delay_out,
    output reg  [10:0] integration_rows_out,
    output reg  [10:0] reset_row_out,
    // Black level outputs
    output reg         black_loop_enable_out,
    output reg  [2:0]  black_loop_speed_out,
    output reg  [7:0]  black_goal_value_out,
    output reg  [7:0]  black_level_manual_out,
    // Gain outputs
    output reg  [6:0]  analog_gain_setting_out,
    output reg  [1:0]  channel_zero_map_out,
    output reg  [1:0]  channel_one_map_out,
    output reg  [1:0]  channel_two_map_out,
    output reg  [1:0]  channel_three_map_out
);

    // ***********************************************
    // Double-buffered registers
    // ***********************************************
    localparam NUM_DB = 4;
    wire [7:0] db_addr [0:NUM_DB-1];
    wire [7:0] db_rst  [0:NUM_DB-1];
    wire [7:0] db_mask [0:NUM_DB-1];
    wire [7:0] db_staged [0:NUM_DB-1];
    wire [7:0] db_active [0:NUM_DB-1];

    assign db_addr[0] = `ADDR_ROW_DELAY_UPPER;
    assign db_addr[1] = `ADDR_ROW_DELAY_LOWER;
    assign db_addr[2] = `ADDR_INTEG_ROWS_UPPER;
    assign db_addr[3] = `ADDR_INTEG_ROWS_LOWER;
    assign db_rst[0]  = `RST_ROW_DELAY_UPPER;
    assign db_rst[1]  = `RST_ROW_DELAY_LOWER;
    assign db_rst[2]  = `RST_INTEG_ROWS_UPPER;
    assign db_rst[3]  = `RST_INTEG_ROWS_LOWER;
    assign db_mask[0] = 8'hff;
    assign db_mask[1] = 8'hff;
    assign db_mask[2] = `INTEG_UPPER_MASK;
    assign db_mask[3] = `INTEG_LOWER_MASK;

    // Reload flag so both copies restart at documented values
    reg  init_q;
    wire frame_load;

    // ***********************************************
    // Reset-value reload after reset release
    // ***********************************************
    always @(posedge core_clk_in)
    begin
        if (!rstn_in)
            init_q <= 1'b1;
        else
            init_q <= 1'b0;
    end

    assign frame_load = frame_start_in | init_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DB; gi = gi + 1)
        begin : g_db
            wire       hit;
            wire [7:0] load_data;
            assign hit = reg_write_in && (reg_addr_in == db_addr[gi]);
            assign load_data = init_q ? db_rst[gi]
                                      : (reg_wdata_in & db_mask[gi]);
            double_buffer_stage u_stage
            (
                .core_clk_in    (core_clk_in),
                .rstn_in        (rstn_in),
                .reset_value_in (db_rst[gi]),
                .write_in       (hit | init_q),
                .write_data_in  (load_data),
                .frame_load_in  (frame_load),
                .staged_out     (db_staged[gi]),
                .active_out     (db_active[gi])
            );
        end
    endgenerate

    // ***********************************************
    // Plain registers
    // ***********************************************
    reg [7:0] black_config_q;
    reg [7:0] black_target_q;
    reg [7:0] gain_q;
    reg [7:0] manual_q;
    reg [7:0] chan_map_q;

    always @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            black_config_q <= `RST_BLACK_LOOP_CONFIG;
            black_target_q <= `RST_BLACK_LOOP_TARGET;
            gain_q         <= `RST_ANALOG_GAIN;
            manual_q       <= `RST_BLACK_LEVEL_MANUAL;
            chan_map_q     <= `RST_GAIN_CHANNEL_MAP;
        end
        else
        begin
            if (reg_write_in)
            begin
                case (reg_addr_in)
                    `ADDR_BLACK_LOOP_CONFIG:
                        black_config_q <= reg_wdata_in & `BLACK_CONFIG_MASK;
                    `ADDR_BLACK_LOOP_TARGET:
                        black_target_q <= reg_wdata_in;
                    `ADDR_ANALOG_GAIN:
                        gain_q <= reg_wdata_in & `ANALOG_GAIN_MASK;
                    `ADDR_BLACK_LEVEL_MANUAL:
                        manual_q <= reg_wdata_in;
                    `ADDR_GAIN_CHANNEL_MAP:
                        chan_map_q <= reg_wdata_in;
                    default:
                        chan_map_q <= chan_map_q;
                endcase
            end
        end
    end

    // ***********************************************
    // Read mux
    // ***********************************************
    reg [7:0] rdata_d;
    always @*
    begin
        case (reg_addr_in)
            `ADDR_ROW_DELAY_UPPER:    rdata_d = db_staged[0];
            `ADDR_ROW_DELAY_LOWER:    rdata_d = db_staged[1];
            `ADDR_INTEG_ROWS_UPPER:   rdata_d = db_staged[2];
            `ADDR_INTEG_ROWS_LOWER:   rdata_d = db_staged[3];
            `ADDR_BLACK_LOOP_CONFIG:  rdata_d = black_config_q;
            `ADDR_BLACK_LOOP_TARGET:  rdata_d = black_target_q;
            `ADDR_ANALOG_GAIN:        rdata_d = gain_q;
            `ADDR_BLACK_LEVEL_MANUAL: rdata_d = manual_q;
            `ADDR_GAIN_CHANNEL_MAP:   rdata_d = chan_map_q;
            default:                  rdata_d = 8'h00;
        endcase
    end

    // ***********************************************
    // Output registers
    // ***********************************************
    wire [10:0] integ_d;
    wire [12:0] row_delay_d;
    wire        black_loop_disable;
    wire [2:0]  black_loop_speed;
    assign integ_d = {db_active[2][3:0], db_active[3][6:0]};
    assign row_delay_d = {db_active[0], db_active[1][4:0]};
    assign black_loop_disable =
        black_config_q[`BLACK_LOOP_DISABLE_BIT];
    assign black_loop_speed =
        black_config_q[`BLACK_LOOP_SPEED_MSB:0];

    always @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            reg_rdata_out           <= 8'h00;
            row_delay_out           <= 13'h0000;
            integration_rows_out    <= 11'h000;
            reset_row_out           <= 11'h000;
            black_loop_enable_out   <= 1'b0;
            black_loop_speed_out    <= 3'h0;
            black_goal_value_out    <= 8'h00;
            black_level_manual_out  <= 8'h00;
            analog_gain_setting_out <= 7'h00;
            channel_zero_map_out    <= 2'h0;
            channel_one_map_out     <= 2'h0;
            channel_two_map_out     <= 2'h0;
            channel_three_map_out   <= 2'h0;
        end
        else
        begin
            if (reg_read_in)
                reg_rdata_out <= rdata_d;
            row_delay_out <= row_delay_d;
            integration_rows_out <= integ_d;
            reset_row_out <= readout_row_in + integ_d;
            black_loop_enable_out <= ~black_loop_disable;
            black_loop_speed_out <= black_loop_speed;
            black_goal_value_out    <= black_target_q;
            black_level_manual_out  <= manual_q;
            analog_gain_setting_out <= gain_q[6:0];
            channel_zero_map_out    <= chan_map_q[7:6];
            channel_one_map_out     <= chan_map_q[5:4];
            channel_two_map_out     <= chan_map_q[3:2];
            channel_three_map_out   <= chan_map_q[1:0];
        end
    end

endmodule

// File: test/exposure_regs_checker_assertions.sv
// Checker on the ports of the exposure, gain and black level registers
// Assumes one clock and a synchronous active-low reset
module exposure_regs_checker
(
    // Clock, reset and register port
    input wire        core_clk_in,
    input wire        rstn_in,
    input wire [7:0]  reg_addr_in,
    input wire        reg_write_in,
    input wire [7:0]  reg_wdata_in,
    input wire        reg_read_in,
    input wire [7:0]  reg_rdata_out,
    // Frame timing and outputs
    input wire        frame_start_in,
    input wire [10:0] readout_row_in,
    input wire [10:0] integration_rows_out,
    input wire [10:0] reset_row_out,
    input wire        black_loop_enable_out,
    input wire [2:0]  black_loop_speed_out,
    input wire [7:0]  black_goal_value_out,
    input wire [7:0]  black_level_manual_out,
    input wire [6:0]  analog_gain_setting_out,
    input wire [1:0]  channel_zero_map_out,
    input wire [1:0]  channel_one_map_out,
    input wire [1:0]  channel_two_map_out,
    input wire [1:0]  channel_three_map_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [7:0] write_addr = reg_write_in ? reg_addr_in : 8'hff;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // ********
    // Assertions
    // ********
    a_gain_write: assert property (write_addr == 8'h42 |-> ##2
        analog_gain_setting_out == $past(reg_wdata_in[6:0], 2))
        else $error("gain output mismatch");
    a_manual_write: assert property (write_addr == 8'h46 |-> ##2
        black_level_manual_out == $past(reg_wdata_in, 2))
        else $error("manual level mismatch");
    a_goal_write: assert property (write_addr == 8'h41 |-> ##2
        black_goal_value_out == $past(reg_wdata_in, 2))
        else $error("target level mismatch");
    a_loop_disable: assert property (write_addr == 8'h40 |-> ##2
        black_loop_enable_out != $past(reg_wdata_in[3], 2))
        else $error("loop enable mismatch");
    a_loop_speed: assert property (write_addr == 8'h40 |-> ##2
        black_loop_speed_out == $past(reg_wdata_in[2:0], 2))
        else $error("loop speed mismatch");
    a_map_fields: assert property (write_addr == 8'h4a |-> ##2
        {channel_zero_map_out, channel_one_map_out, channel_two_map_out,
        channel_three_map_out} == $past(reg_wdata_in, 2))
        else $error("channel map mismatch");
    a_rows_staged: assert property (!$past(frame_start_in, 2) |->
        $stable(integration_rows_out)) else $error("rows moved early");
    a_upper_reserved: assert property (reg_read_in &&
        reg_addr_in == 8'h24 |=> reg_rdata_out[7:4] == 4'h0)
        else $error("reserved bits read back");
    a_reset_lead: assert property ($past(rstn_in, 2) &&
        $stable(integration_rows_out) |-> reset_row_out ==
        $past(readout_row_in) + integration_rows_out) else $error("reset row");
    c_frame_load: cover property (frame_start_in ##2
        $changed(integration_rows_out));
    c_map_read: cover property (reg_read_in && reg_addr_in == 8'h4a);
    c_gain_set: cover property (write_addr == 8'h42 ##2
        analog_gain_setting_out != 7'h00);
endmodule

bind exposure_gain_blacklevel_regs exposure_regs_checker u_exposure_regs_checker
(
    .core_clk_in, .rstn_in, .reg_addr_in, .reg_write_in, .reg_wdata_in,
    .reg_read_in, .reg_rdata_out, .frame_start_in, .readout_row_in,
    .integration_rows_out, .reset_row_out, .black_loop_enable_out,
    .black_loop_speed_out, .black_goal_value_out, .black_level_manual_out,
    .analog_gain_setting_out, .channel_zero_map_out, .channel_one_map_out,
    .channel_two_map_out, .channel_three_map_out
);

// File: test/test_exposure_gain_blacklevel_regs.sv
// Self-checking bench for the exposure, gain and black level registers
// Assumes registered read data and two-edge output latency
module test_exposure_gain_blacklevel_regs;
    timeunit 1ns;
    timeprecision 1ps;
    reg         core_clk_in = 1'b0;
    reg         rstn_in = 1'b0;
    reg  [7:0]  reg_addr_in = 8'h00;
    reg         reg_write_in = 1'b0;
    reg  [7:0]  reg_wdata_in = 8'h00;
    reg         reg_read_in = 1'b0;
    reg         frame_start_in = 1'b0;
    reg  [10:0] readout_row_in = 11'h000;
    wire [7:0]  reg_rdata_out;
    wire [12:0] row_delay_out;
    wire [10:0] integration_rows_out, reset_row_out;
    wire        black_loop_enable_out;
    wire [2:0]  black_loop_speed_out;
    wire [7:0]  black_goal_value_out, black_level_manual_out;
    wire [6:0]  analog_gain_setting_out;
    wire [1:0]  channel_zero_map_out, channel_one_map_out;
    wire [1:0]  channel_two_map_out, channel_three_map_out;
    reg  [71:0] adl = 72'h22_23_24_25_40_41_42_46_4a;
    reg  [71:0] rstl = 72'h00_08_00_00_07_10_00_00_1b;
    reg  [7:0]  sv [0:8];
    reg  [7:0]  d;
    reg  [10:0] ex;
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     r, i;
    always #25 core_clk_in = ~core_clk_in;
    exposure_gain_blacklevel_regs u_exposure_gain_blacklevel_regs
    (
        .core_clk_in, .rstn_in, .reg_addr_in, .reg_write_in, .reg_wdata_in,
        .reg_read_in, .reg_rdata_out, .frame_start_in, .readout_row_in,
        .row_delay_out, .integration_rows_out, .reset_row_out,
        .black_loop_enable_out, .black_loop_speed_out, .black_goal_value_out,
        .black_level_manual_out, .analog_gain_setting_out,
        .channel_zero_map_out, .channel_one_map_out, .channel_two_map_out,
        .channel_three_map_out
    );
    // ********
    // Tasks
    // ********
    function [7:0] keep(input [7:0] a, input [7:0] v);
        case (a)
            8'h24, 8'h40: keep = v & 8'h0f;
            8'h25, 8'h42: keep = v & 8'h7f;
            8'h22, 8'h23, 8'h41, 8'h46, 8'h4a: keep = v;
            default: keep = 8'h00;
        endcase
    endfunction
    task chk(input [12:0] seen, input [12:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        chk(reg_rdata_out, exp);
    endtask
    task outs;
        repeat (2) @(posedge core_clk_in);
        #1;
        ex = readout_row_in + {sv[2][3:0], sv[3][6:0]};
        chk(row_delay_out, {sv[0], sv[1][4:0]});
        chk(integration_rows_out, {sv[2][3:0], sv[3][6:0]});
        chk(reset_row_out, ex);
        chk(black_loop_enable_out, !sv[4][3]);
        chk(black_loop_speed_out, sv[4][2:0]);
        chk(black_goal_value_out, sv[5]);
        chk(analog_gain_setting_out, sv[6][6:0]);
        chk(black_level_manual_out, sv[7]);
        chk({channel_zero_map_out, channel_one_map_out,
            channel_two_map_out, channel_three_map_out}, sv[8]);
    endtask
    task do_reset;
        @(posedge core_clk_in);
        rstn_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        for (i = 0; i < 9; i = i + 1)
        begin
            sv[i] = rstl[71-8*i -: 8];
            rd(adl[71-8*i -: 8], sv[i]);
        end
        outs;
    endtask
    task results;
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ********
    // Sequence
    // ********
    initial
    begin
        void'($urandom(32'hf5d129cc));
        do_reset;
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        for (r = 0; r < 5; r = r + 1)
        begin
            @(posedge core_clk_in);
            readout_row_in <= $urandom;
            ex = {sv[2][3:0], sv[3][6:0]};
            for (i = 0; i < 9; i = i + 1)
            begin
                d = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : $urandom;
                if (adl[71-8*i -: 8] == 8'h24)
                    d = d & 8'hf2;
                sv[i] = keep(adl[71-8*i -: 8], d);
                wr(adl[71-8*i -: 8], d);
                rd(adl[71-8*i -: 8], sv[i]);
            end
            chk(integration_rows_out, ex);
            @(posedge core_clk_in);
            frame_start_in <= 1'b1;
            @(posedge core_clk_in);
            frame_start_in <= 1'b0;
            outs;
        end
        do_reset;
        results;
    end
endmodule
